/* File: src/exec_pkg.sv */
package exec_pkg;

  // register map, byte offsets within the slave window
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INSN = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_GPR0 = 8'h40;
  localparam logic [7:0] OFF_GPR7 = 8'h5c;
  localparam logic [7:0] OFF_SP = 8'h60;
  localparam logic [7:0] OFF_LR = 8'h64;
  localparam logic [7:0] OFF_PC = 8'h68;

  // field positions
  localparam int unsigned CTRL_ALIGN_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_ABORT_BIT = 1;
  localparam int unsigned STAT_ALIGN_BIT = 2;
  localparam int unsigned STAT_UNDEF_BIT = 3;
  localparam int unsigned STAT_V_BIT = 28;
  localparam int unsigned STAT_C_BIT = 29;
  localparam int unsigned STAT_Z_BIT = 30;
  localparam int unsigned STAT_N_BIT = 31;
  localparam int unsigned EXTRA_BIT = 8;

  // instruction encodings
  localparam logic [9:0] ENC_OR = 10'h10c;
  localparam logic [9:0] ENC_SBC = 10'h106;
  localparam logic [9:0] ENC_ROR = 10'h107;
  localparam logic [6:0] ENC_POP = 7'h5e;
  localparam logic [6:0] ENC_PUSH = 7'h5a;
  localparam logic [4:0] ENC_STM = 5'h18;

  // reset values, extra slot mask and index
  localparam logic [31:0] RST_WORD = 32'h0;
  localparam logic [15:0] RST_INSN = 16'h0;
  localparam logic [8:0] EXTRA_SLOT = 9'h100;
  localparam logic [3:0] EXTRA_IDX = 4'h8;

  typedef enum logic [1:0] {
    OP_POP,
    OP_PUSH,
    OP_STM
  } xfer_op_t;

  typedef enum logic {
    PH_IDLE,
    PH_XFER
  } phase_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } flags_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;

endpackage : exec_pkg

/* File: src/compact_exec.sv */
// Summary of operation
// RL1: bitwise_or_op ORs source into destination; N,Z from result, C from shifter, V kept.
// RL2: pop loads listed registers ascending from ascending words starting at stack_pointer.
// RL3: pop last address is stack_pointer plus four per selected register minus four.
// RL4: pop with bit 8 also loads program_counter from the following word.
// RL5: pop and push add four per selected register, extra bit included, to stack_pointer.
// RL6: on data abort stack_pointer keeps either original or updated value; original chosen.
// RL7: multiple transfers ignore the two low address bits and never rotate words.
// RL8: with alignment checking on, a misaligned multiple-transfer base raises an alignment fault.
// RL9: push stores listed registers ascending to ascending words starting at stack_pointer.
// RL10: push with bit 8 also stores link_reg in the word after the list.
// RL11: subtract_with_borrow_op computes destination minus source minus not carry into destination.
// RL12: subtract_with_borrow_op sets N,Z from result; C,V from the whole subtraction.
// RL13: store_multi_ascending stores listed registers ascending from base_reg value upward.
// RL14: store_multi_ascending adds four per listed register to base_reg afterwards.
// RL15: rotate_right_op uses low byte of shift_amount_reg; zero leaves value and carry.
`timescale 1ns/1ns
module compact_exec (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // data memory
  output exec_pkg::mem_req_t mem_o,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic mem_abort,
  // status
  output logic busy
);

  typedef struct packed {
    logic [7:0][31:0] gpr;
    logic [31:0] sp;
    logic [31:0] lr;
    logic [31:0] pc;
    exec_pkg::flags_t fl;
    logic align_en;
    logic [15:0] insn;
    logic abort_seen;
    logic align_seen;
    logic undef_seen;
    exec_pkg::phase_t phase;
    exec_pkg::xfer_op_t op;
    logic [8:0] mask;
    logic [3:0] cur;
    logic [2:0] base_idx;
    logic [31:0] addr;
    logic [31:0] new_base;
    exec_pkg::mem_req_t mem;
    logic ap_write;
    logic rd_pend;
    logic [7:0] ap_addr;
    logic hready;
    logic [31:0] hrdata;
  } state_t;

  state_t q_ff;
  state_t nxt_q;

  logic [31:0] op_a;
  logic [31:0] op_b;
  logic [31:0] res;
  logic [32:0] diff;
  logic [63:0] rot;
  logic [31:0] base;
  logic [3:0] cnt;
  logic [3:0] idx;
  logic [15:0] ins;

  function automatic logic [3:0] lowest(input logic [8:0] m);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 8; i >= 0; i--) begin
      if (m[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : lowest

  function automatic logic [3:0] ones(input logic [8:0] m);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 9; i++) begin
      c = c + {3'h0, m[i]};
    end
    return c;
  endfunction : ones

  function automatic logic [31:0] read_reg(input state_t s,
                                           input logic [7:0] a);
    logic [31:0] d;
    d = exec_pkg::RST_WORD;
    if (a == exec_pkg::OFF_CTRL) begin
      d[exec_pkg::CTRL_ALIGN_BIT] = s.align_en;
    end else if (a == exec_pkg::OFF_INSN) begin
      d[15:0] = s.insn;
    end else if (a == exec_pkg::OFF_STATUS) begin
      d[exec_pkg::STAT_BUSY_BIT] = (s.phase != exec_pkg::PH_IDLE);
      d[exec_pkg::STAT_ABORT_BIT] = s.abort_seen;
      d[exec_pkg::STAT_ALIGN_BIT] = s.align_seen;
      d[exec_pkg::STAT_UNDEF_BIT] = s.undef_seen;
      d[exec_pkg::STAT_N_BIT] = s.fl.n;
      d[exec_pkg::STAT_Z_BIT] = s.fl.z;
      d[exec_pkg::STAT_C_BIT] = s.fl.c;
      d[exec_pkg::STAT_V_BIT] = s.fl.v;
    end else if (a >= exec_pkg::OFF_GPR0 && a <= exec_pkg::OFF_GPR7) begin
      d = s.gpr[a[4:2]];
    end else if (a == exec_pkg::OFF_SP) begin
      d = s.sp;
    end else if (a == exec_pkg::OFF_LR) begin
      d = s.lr;
    end else if (a == exec_pkg::OFF_PC) begin
      d = s.pc;
    end
    return d;
  endfunction : read_reg

  always_comb begin
    nxt_q = q_ff;
    ins = hwdata[15:0];
    op_a = q_ff.gpr[ins[2:0]];
    op_b = q_ff.gpr[ins[5:3]];
    res = op_a;
    diff = 33'h0;
    rot = {op_a, op_a} >> op_b[4:0];
    base = q_ff.sp;
    cnt = 4'h0;
    idx = lowest(q_ff.mask);

    // address phase; hsize ignored, only whole words are mapped
    if (hsel && hready && htrans[1]) begin
      nxt_q.ap_write = hwrite;
      nxt_q.ap_addr = haddr[7:0];
      if (!hwrite) begin
        // one wait state so a read sees a write from the cycle before
        nxt_q.rd_pend = 1'b1;
        nxt_q.hready = 1'b0;
      end
    end else begin
      nxt_q.ap_write = 1'b0;
    end
    if (q_ff.rd_pend) begin
      nxt_q.hrdata = read_reg(q_ff, q_ff.ap_addr);
      nxt_q.hready = 1'b1;
      nxt_q.rd_pend = 1'b0;
    end

    // write data phase; most writes are refused while a transfer runs
    if (q_ff.ap_write) begin
      if (q_ff.ap_addr == exec_pkg::OFF_CTRL) begin
        nxt_q.align_en = hwdata[exec_pkg::CTRL_ALIGN_BIT];
      end else if (q_ff.phase == exec_pkg::PH_IDLE) begin
        if (q_ff.ap_addr == exec_pkg::OFF_STATUS) begin
          nxt_q.fl.n = hwdata[exec_pkg::STAT_N_BIT];
          nxt_q.fl.z = hwdata[exec_pkg::STAT_Z_BIT];
          nxt_q.fl.c = hwdata[exec_pkg::STAT_C_BIT];
          nxt_q.fl.v = hwdata[exec_pkg::STAT_V_BIT];
        end else if (q_ff.ap_addr >= exec_pkg::OFF_GPR0 &&
                     q_ff.ap_addr <= exec_pkg::OFF_GPR7) begin
          nxt_q.gpr[q_ff.ap_addr[4:2]] = hwdata;
        end else if (q_ff.ap_addr == exec_pkg::OFF_SP) begin
          nxt_q.sp = hwdata;
        end else if (q_ff.ap_addr == exec_pkg::OFF_LR) begin
          nxt_q.lr = hwdata;
        end else if (q_ff.ap_addr == exec_pkg::OFF_PC) begin
          nxt_q.pc = hwdata;
        end else if (q_ff.ap_addr == exec_pkg::OFF_INSN) begin
          nxt_q.insn = ins;
          nxt_q.abort_seen = 1'b0;
          nxt_q.align_seen = 1'b0;
          nxt_q.undef_seen = 1'b0;
          if (ins[15:6] == exec_pkg::ENC_OR) begin
            res = op_a | op_b; // RL1
            nxt_q.gpr[ins[2:0]] = res;
            nxt_q.fl.n = res[31]; // RL1
            nxt_q.fl.z = (res == exec_pkg::RST_WORD); // RL1
            // register operand: shifter carry-out is the carry itself
          end else if (ins[15:6] == exec_pkg::ENC_SBC) begin
            diff = {1'b0, op_a} - {1'b0, op_b} - {32'h0, ~q_ff.fl.c}; // RL11
            res = diff[31:0];
            nxt_q.gpr[ins[2:0]] = res; // RL11
            nxt_q.fl.n = res[31]; // RL12
            nxt_q.fl.z = (res == exec_pkg::RST_WORD); // RL12
            nxt_q.fl.c = ~diff[32]; // RL12
            nxt_q.fl.v = (op_a[31] ^ op_b[31]) & (op_a[31] ^ res[31]); // RL12
          end else if (ins[15:6] == exec_pkg::ENC_ROR) begin
            if (op_b[7:0] != 8'h00) begin
              res = rot[31:0]; // RL15
              nxt_q.fl.c = res[31]; // RL15
            end
            nxt_q.gpr[ins[2:0]] = res;
            nxt_q.fl.n = res[31]; // RL15
            nxt_q.fl.z = (res == exec_pkg::RST_WORD); // RL15
          end else if (ins[15:9] == exec_pkg::ENC_POP ||
                       ins[15:9] == exec_pkg::ENC_PUSH ||
                       ins[15:11] == exec_pkg::ENC_STM) begin
            if (ins[15:11] == exec_pkg::ENC_STM) begin
              nxt_q.op = exec_pkg::OP_STM;
              base = q_ff.gpr[ins[10:8]];
              nxt_q.mask = {1'b0, ins[7:0]};
            end else begin
              nxt_q.op = (ins[11]) ? exec_pkg::OP_POP : exec_pkg::OP_PUSH;
              nxt_q.mask = ins[8:0]; // RL4 RL10
            end
            nxt_q.base_idx = ins[10:8];
            cnt = ones(nxt_q.mask);
            if (q_ff.align_en && base[1:0] != 2'b00) begin
              nxt_q.align_seen = 1'b1; // RL8
            end else begin
              nxt_q.phase = exec_pkg::PH_XFER;
              nxt_q.addr = {base[31:2], 2'b00}; // RL7
              // final address is new_base - 4 with the two low bits cleared
              nxt_q.new_base = base + {26'h0, cnt, 2'b00}; // RL3 RL5 RL14
            end
          end else begin
            nxt_q.undef_seen = 1'b1;
          end
        end
      end
    end

    // one word per memory handshake, lowest register first
    if (q_ff.phase == exec_pkg::PH_XFER) begin
      if (!q_ff.mem.req) begin
        if (q_ff.mask == 9'h000) begin
          nxt_q.phase = exec_pkg::PH_IDLE;
          if (q_ff.op == exec_pkg::OP_STM) begin
            nxt_q.gpr[q_ff.base_idx] = q_ff.new_base; // RL14
          end else begin
            nxt_q.sp = q_ff.new_base; // RL5
          end
        end else begin
          nxt_q.cur = idx;
          nxt_q.mem.req = 1'b1;
          nxt_q.mem.we = (q_ff.op != exec_pkg::OP_POP);
          nxt_q.mem.addr = q_ff.addr;
          if (idx == exec_pkg::EXTRA_IDX) begin
            nxt_q.mem.wdata = q_ff.lr; // RL10
          end else begin
            nxt_q.mem.wdata = q_ff.gpr[idx[2:0]]; // RL9 RL13
          end
        end
      end else if (mem_abort) begin
        // base keeps its original value, writeback is only at the end
        nxt_q.mem.req = 1'b0;
        nxt_q.abort_seen = 1'b1;
        nxt_q.phase = exec_pkg::PH_IDLE; // RL6
      end else if (mem_ack) begin
        nxt_q.mem.req = 1'b0;
        if (q_ff.op == exec_pkg::OP_POP) begin
          // data used as delivered, no byte rotation
          if (q_ff.cur == exec_pkg::EXTRA_IDX) begin
            nxt_q.pc = mem_rdata; // RL4 RL7
          end else begin
            nxt_q.gpr[q_ff.cur[2:0]] = mem_rdata; // RL2 RL7
          end
        end
        nxt_q.mask[q_ff.cur] = 1'b0;
        nxt_q.addr = q_ff.addr + 32'h4; // RL2 RL9 RL13
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_ff <= '0;
      q_ff.hready <= 1'b1;
      q_ff.phase <= exec_pkg::PH_IDLE;
      q_ff.op <= exec_pkg::OP_POP;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign hreadyout = q_ff.hready;
  assign hresp = 1'b0;
  assign hrdata = q_ff.hrdata;
  assign mem_o = q_ff.mem;
  assign busy = (q_ff.phase != exec_pkg::PH_IDLE);

endmodule : compact_exec

/* File: sim/exec_props.sv */
`timescale 1ns/1ns
module exec_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // memory and status
  input exec_pkg::mem_req_t mem_o,
  input wire logic mem_ack,
  input wire logic mem_abort,
  input wire logic busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] last_ff;
  logic have_ff;
  wire done = mem_o.req & (mem_ack | mem_abort);
  // last completed word of the running transfer
  always_ff @(posedge clk) begin
    if (rst || !busy) have_ff <= 1'b0;
    else if (done) have_ff <= 1'b1;
    if (done) last_ff <= mem_o.addr;
  end
  word_aligned_a: assert property (mem_o.req |-> mem_o.addr[1:0] == 2'h0)
    else $error("memory address not word aligned");
  req_held_a: assert property (mem_o.req && !mem_ack && !mem_abort |=>
    mem_o.req && $stable(mem_o.addr) && $stable(mem_o.wdata))
    else $error("memory request changed before answer");
  addr_step_a: assert property ($rose(mem_o.req) && have_ff |->
    mem_o.addr == last_ff + 32'h4)
    else $error("next word address not previous plus four");
  req_in_busy_a: assert property (mem_o.req |-> busy)
    else $error("memory request outside a transfer");
  abort_stops_a: assert property (done && mem_abort |=> !mem_o.req [*4])
    else $error("words issued after abort");
  req_gap_a: assert property (done |=> !mem_o.req)
    else $error("request not dropped after answer");
  read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=>
    !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  cover property (done && mem_o.we);
  cover property (done && !mem_o.we && mem_ack);
  cover property (done && mem_abort);
endmodule : exec_props

/* File: sim/mem_model.sv */
`timescale 1ns/1ns
module mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // memory port
  input exec_pkg::mem_req_t mem_o,
  output logic [31:0] mem_rdata,
  output logic mem_ack,
  output logic mem_abort,
  // scenario controls
  input wire logic slow,
  input wire logic fail
);
  logic [31:0] mem [0:255];
  logic [2:0] wait_ff;
  always_ff @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_abort <= 1'b0;
    // read data is garbage outside the answer cycle
    mem_rdata <= ~mem_rdata;
    if (rst) begin
      wait_ff <= 3'h0;
      mem_rdata <= 32'h5a5a_5a5a;
    end else if (mem_o.req && !mem_ack && !mem_abort) begin
      wait_ff <= wait_ff + 3'h1;
      if (!slow || wait_ff == 3'h4) begin
        wait_ff <= 3'h0;
        mem_abort <= fail;
        mem_ack <= !fail;
        if (mem_o.we && !fail) mem[mem_o.addr[9:2]] <= mem_o.wdata;
        mem_rdata <= mem[mem_o.addr[9:2]];
      end
    end
  end
endmodule : mem_model

/* File: sim/tb_compact_exec.sv */
`timescale 1ns/1ns
module tb_compact_exec;
  localparam logic [7:0] G = exec_pkg::OFF_GPR0;
  localparam logic [7:0] S = exec_pkg::OFF_STATUS;
  localparam logic [7:0] SP = exec_pkg::OFF_SP;
  logic clk, rst, hsel, hwrite, hready, slow, fail, busy;
  logic hreadyout, hresp, mem_ack, mem_abort;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, mem_rdata, q;
  exec_pkg::mem_req_t mem_o;
  int errors, n_compared;
  assign hready = hreadyout;
  compact_exec i_compact_exec (.clk, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .mem_o,
    .mem_rdata, .mem_ack, .mem_abort, .busy);
  mem_model i_mem_model (.clk, .rst, .mem_o, .mem_rdata, .mem_ack,
    .mem_abort, .slow, .fail);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  // entered just after a rising edge, leaves just after one
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk iff hready);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk iff hready);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e, string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rc
  task automatic run(input logic [15:0] insn);
    wr(exec_pkg::OFF_INSN, {16'h0, insn});
    repeat (3) @(posedge clk);
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk);
    // a transfer that never ends counts as a mismatch
    chk("busy after run", 32'h0, {31'h0, busy});
  endtask : run
  task automatic print_verdict();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #40000;
    errors++;
    print_verdict();
  end
  initial begin
    {rst, hsel, htrans, hwrite, haddr, hwdata} = {1'b1, 68'h0};
    {hsize, slow, fail, errors, n_compared} = {3'h2, 2'h0, 64'h0};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wr(S, 32'h3000_0000);
    wr(G, 32'h8000_0001);
    wr(G + 8'h04, 32'h10);
    run(16'h4308);
    rc(G, 32'h8000_0011, "or r0");
    rc(S, 32'hb000_0000, "or flags");
    wr(S, 32'h0);
    wr(G + 8'h08, 32'h5);
    wr(G + 8'h0c, 32'h5);
    run(16'h419a);
    rc(G + 8'h08, 32'hffff_ffff, "sbc r2");
    rc(S, 32'h8000_0000, "sbc flags");
    wr(S, 32'h2000_0000);
    wr(G + 8'h08, 32'h8000_0000);
    wr(G + 8'h0c, 32'h1);
    run(16'h419a);
    rc(G + 8'h08, 32'h7fff_ffff, "sbc r2 b");
    rc(S, 32'h3000_0000, "sbc flags b");
    wr(S, 32'h0);
    wr(G + 8'h10, 32'h1);
    wr(G + 8'h14, 32'h21);
    run(16'h41ec);
    rc(G + 8'h10, 32'h8000_0000, "ror r4");
    rc(S, 32'ha000_0000, "ror flags");
    wr(S, 32'h0);
    wr(G + 8'h14, 32'h100);
    run(16'h41ec);
    rc(G + 8'h10, 32'h8000_0000, "ror zero r4");
    rc(S, 32'h8000_0000, "ror zero flags");
    wr(SP, 32'h103);
    wr(exec_pkg::OFF_LR, 32'haaaa_0001);
    run(16'hb505);
    chk("push w0", 32'h8000_0011, i_mem_model.mem[8'h40]);
    chk("push w1", 32'h7fff_ffff, i_mem_model.mem[8'h41]);
    chk("push lr", 32'haaaa_0001, i_mem_model.mem[8'h42]);
    rc(SP, 32'h10f, "push sp");
    slow <= 1'b1;
    wr(SP, 32'h100);
    run(16'hbd0a);
    rc(G + 8'h04, 32'h8000_0011, "pop r1");
    rc(G + 8'h0c, 32'h7fff_ffff, "pop r3");
    rc(exec_pkg::OFF_PC, 32'haaaa_0001, "pop pc");
    rc(SP, 32'h10c, "pop sp");
    wr(SP, 32'h104);
    wr(exec_pkg::OFF_PC, 32'h0);
    run(16'hbc02);
    rc(exec_pkg::OFF_PC, 32'h0, "pop no pc");
    rc(SP, 32'h108, "pop sp b");
    slow <= 1'b0;
    wr(G + 8'h18, 32'h200);
    wr(G + 8'h1c, 32'h77);
    run(16'hc681);
    chk("stm w0", 32'h8000_0011, i_mem_model.mem[8'h80]);
    chk("stm w1", 32'h77, i_mem_model.mem[8'h81]);
    rc(G + 8'h18, 32'h208, "stm base");
    fail <= 1'b1;
    wr(SP, 32'h100);
    run(16'hbc02);
    fail <= 1'b0;
    rc(SP, 32'h100, "abort sp");
    bus(1'b0, S, 32'h0);
    chk("abort bit", 32'h2, q & 32'h2);
    wr(exec_pkg::OFF_CTRL, 32'h1);
    wr(SP, 32'h102);
    run(16'hb401);
    bus(1'b0, S, 32'h0);
    chk("align bit", 32'h4, q & 32'h4);
    wr(8'h80, 32'hffff_ffff);
    rc(8'h80, 32'h0, "unmapped");
    print_verdict();
  end
endmodule : tb_compact_exec
bind compact_exec exec_props i_exec_props (.clk, .rst, .hsel, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .mem_o, .mem_ack, .mem_abort, .busy);
